/* hdl/csn_top.sv */
// serial-state notifier with pipe map, line coding and wishbone registers
//
// What this block and the host do
// R1: only the serial-state notification code 0x20 is ever sent.
// R2: uart overrun, parity and framing errors map to bitmap bits 6, 5, 4.
// R3: a change from no error to an error starts a notification.
// R4: an error that persists sends nothing more until it clears and recurs.
// R5: each notification has header a1 20 0000 0000 0002 then a 2-byte map.
// R6: bitmap bits 3..0 and 15..7 are always zero.
// R7: bulk out data uses endpoint 2 and bulk in data uses endpoint 1.
// R8: bulk in and bulk out use distinct pipes in the range 1 to 5.
// R9: the interrupt in notification pipe lies in the range 6 to 9.
// R10: the host reads line coding and sets line state after enumeration.
// R11: the host sends set-line-coding whenever its port settings change.
// R12: the host ends a bulk in transfer on a short packet.
// R13: line coding is 7 bytes: 4-byte rate, stop, parity, data bits.
// R14: a bulk in transfer ending on a full packet gets a zero-length packet.
`timescale 1ns/1ps
module csn_top
  import csn_pkg::*;
#(
  parameter logic [10:0] MAX_PKT = 11'd64
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // uart error levels: overrun, parity, framing
  input  wire logic [2:0]  uart_err_i,
  // line coding bytes from set-line-coding data stage
  input  wire logic        lc_we_i,
  input  wire logic [2:0]  lc_idx_i,
  input  wire logic [7:0]  lc_byte_i,
  // bulk in packet report from the endpoint engine
  input  wire logic        bi_pkt_i,
  input  wire logic [10:0] bi_len_i,
  input  wire logic        bi_last_i,
  output logic             bi_zlp_o,
  // endpoint and pipe map for the endpoint engine
  output logic [3:0]       bi_ep_o,
  output logic [3:0]       bo_ep_o,
  output logic [3:0]       bi_pipe_o,
  output logic [3:0]       bo_pipe_o,
  output logic [3:0]       int_pipe_o,
  output logic             pipe_ok_o,
  // notification bytes toward the interrupt in pipe
  output logic [7:0]       ntf_data_o,
  output logic             ntf_valid_o,
  output logic             ntf_last_o,
  input  wire logic        ntf_ready_i
);
  csn_ntf_if ntf ();

  logic [31:0]     ctrl;
  logic [11:0]     pipe_cfg;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] ev;
  logic [7:0]      lc [0:6];
  logic [2:0]      err_q;
  logic [2:0]      rise;
  logic [2:0]      pend;
  logic            issue;
  logic            wb_hit;
  logic            wb_wr;
  logic            lc_done;
  logic            cfg_good;
  logic [31:0]     next_rdata;
  logic [31:0]     next_pipe;

  // pipe range and distinctness check, used for both the live and new map
  function automatic logic pipes_valid(input logic [11:0] p);
    pipes_valid = p[3:0] >= PIPE_BULK_MIN && p[3:0] <= PIPE_BULK_MAX
               && p[7:4] >= PIPE_BULK_MIN && p[7:4] <= PIPE_BULK_MAX
               && p[3:0] != p[7:4]
               && p[11:8] >= PIPE_INT_MIN && p[11:8] <= PIPE_INT_MAX;
  endfunction

  // byte-lane merge for writable registers
  function automatic logic [31:0] lane(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0]  sel);
    for (int b = 0; b < 4; b++)
      lane[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
  endfunction

  // wishbone strobes; ack comes one cycle after the request is seen
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_hit && wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_hit;
  end

  // read mux; unmapped addresses read zero and still ack
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      REG_CTRL:    next_rdata = ctrl;
      REG_PIPE:    next_rdata = {19'h0, pipe_ok_o, pipe_cfg};
      REG_STATUS:  next_rdata = {28'h0, status};
      REG_MASK:    next_rdata = {28'h0, mask};
      REG_LC_RATE: next_rdata = {lc[3], lc[2], lc[1], lc[0]}; // R13
      REG_LC_FMT:  next_rdata = {8'h00, lc[6], lc[5], lc[4]}; // R13
      REG_ERR:     next_rdata = {25'h0, err_q, pend, ntf.busy};
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (wb_hit && !wb_we_i)
      wb_dat_o <= next_rdata;
  end

  // control: bit 0 enables notifications
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= CTRL_RST;
    else if (wb_wr && wb_adr_i == REG_CTRL)
      ctrl <= lane(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0001;
  end

  // pipe map: an illegal write is refused and flagged, old map stays
  // merged candidate map; a function result cannot be sliced directly
  assign next_pipe = lane({20'h0, pipe_cfg}, wb_dat_i, wb_sel_i);
  assign cfg_good  = pipes_valid(next_pipe[11:0]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pipe_cfg <= PIPE_RST;
    else if (wb_wr && wb_adr_i == REG_PIPE && cfg_good)
      pipe_cfg <= next_pipe[11:0]; // R8
  end

  // pipe and endpoint outputs straight from flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bi_ep_o    <= EP_BULK_IN;
      bo_ep_o    <= EP_BULK_OUT;
      bi_pipe_o  <= PIPE_RST[3:0];
      bo_pipe_o  <= PIPE_RST[7:4];
      int_pipe_o <= PIPE_RST[11:8];
      pipe_ok_o  <= 1'b0;
    end
    else
    begin
      bi_ep_o    <= EP_BULK_IN; // R7
      bo_ep_o    <= EP_BULK_OUT; // R7
      bi_pipe_o  <= pipe_cfg[3:0]; // R8
      bo_pipe_o  <= pipe_cfg[7:4]; // R8
      int_pipe_o <= pipe_cfg[11:8]; // R9
      pipe_ok_o  <= pipes_valid(pipe_cfg); // R8 R9
    end
  end

  // line coding store; host resends it on every settings change
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      for (int i = 0; i < 7; i++)
        lc[i] <= 8'h00;
    else if (lc_we_i && lc_idx_i < LC_LEN)
      lc[lc_idx_i] <= lc_byte_i; // R13 R11
  end
  assign lc_done = lc_we_i && lc_idx_i == LC_IDX_DBITS;

  // uart errors come from logic on this clock, so no synchroniser
  assign rise = uart_err_i & ~err_q; // R3

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      err_q <= 3'h0;
    else
      err_q <= uart_err_i;
  end

  // pending edges; a new edge in the issue cycle survives the clear
  assign issue = ctrl[0] && pend != 3'h0 && !ntf.busy && !ntf.req
              && pipe_ok_o;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend <= 3'h0;
    else
      pend <= (issue ? 3'h0 : pend) | rise; // R3 R4
  end

  // request to the serialiser, bits placed at their bitmap positions
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ntf.req    <= 1'b0;
      ntf.bitmap <= 16'h0000;
    end
    else if (issue)
    begin
      ntf.req    <= 1'b1;
      ntf.bitmap <= 16'h0000;
      ntf.bitmap[BIT_OVERRUN] <= pend[2]; // R2
      ntf.bitmap[BIT_PARITY]  <= pend[1]; // R2
      ntf.bitmap[BIT_FRAMING] <= pend[0]; // R2
    end
    else if (ntf.busy)
      ntf.req <= 1'b0;
  end

  csn_ntf_tx u_tx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ntf     (ntf.tx),
    .data_o  (ntf_data_o),
    .valid_o (ntf_valid_o),
    .last_o  (ntf_last_o),
    .ready_i (ntf_ready_i)
  );

  // zero-length packet after a transfer ending on a full packet,
  // since the host only closes a transfer on a short one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      bi_zlp_o <= 1'b0;
    else
      bi_zlp_o <= bi_pkt_i && bi_last_i && bi_len_i == MAX_PKT; // R14 R12
  end

  // interrupt events, sticky until written with one; set wins
  assign ev[ST_NTF_SENT]   = ntf.done;
  assign ev[ST_LC_CHANGED] = lc_done;
  assign ev[ST_ZLP_SENT]   = bi_zlp_o;
  assign ev[ST_CFG_ERR]    = wb_wr && wb_adr_i == REG_PIPE && !cfg_good;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= '0;
    else if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0])
      status <= (status & ~wb_dat_i[ST_W-1:0]) | ev;
    else
      status <= status | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask <= '0;
    else if (wb_wr && wb_adr_i == REG_MASK && wb_sel_i[0])
      mask <= wb_dat_i[ST_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status & mask);
  end

  // a rising error is either queued or already being announced
  sequence s_err_rises;
    rise != 3'h0;
  endsequence
  sequence s_err_held;
    pend != 3'h0 || ntf.req;
  endsequence

  AST_EDGE_NOTIFIES: assert property (@(posedge clk_i) disable iff (rst_i)
    s_err_rises |=> s_err_held) // R3
    else $error("error edge was dropped");
  AST_PERSIST_QUIET: assert property (@(posedge clk_i) disable iff (rst_i)
    pend == 3'h0 && rise == 3'h0 |=> pend == 3'h0) // R4
    else $error("notification pending without a fresh error edge");
  AST_MAP_POS: assert property (@(posedge clk_i) disable iff (rst_i)
    issue |=> ntf.bitmap == {9'h0, $past(pend), 4'h0}) // R2
    else $error("error bits not at bitmap positions 6..4");
  AST_PIPES_LEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
    pipe_ok_o |-> bi_pipe_o != bo_pipe_o && int_pipe_o >= PIPE_INT_MIN
      && int_pipe_o <= PIPE_INT_MAX && bi_pipe_o <= PIPE_BULK_MAX) // R8 R9
    else $error("pipe map out of range");
  AST_ENDPOINTS: assert property (@(posedge clk_i) disable iff (rst_i)
    bi_ep_o == EP_BULK_IN && bo_ep_o == EP_BULK_OUT) // R7
    else $error("bulk endpoints wrong");
  AST_ZLP_FULL: assert property (@(posedge clk_i) disable iff (rst_i)
    bi_pkt_i && bi_last_i && bi_len_i == MAX_PKT |=> bi_zlp_o) // R14
    else $error("no zero-length packet after full last packet");
  AST_LC_BITS: assert property (@(posedge clk_i) disable iff (rst_i)
    lc_done |=> lc[LC_IDX_DBITS] == $past(lc_byte_i)) // R13
    else $error("data-bit byte not stored");
endmodule

/* hdl/csn_pkg.sv */
// constants shared by the serial-state notifier files
package csn_pkg;
  // notification header (setup-style)
  localparam logic [7:0]  NTF_REQ_TYPE   = 8'ha1;
  localparam logic [7:0]  NTF_SERIAL_ST  = 8'h20;
  localparam logic [7:0]  NTF_NET_CONN   = 8'h00;
  localparam logic [7:0]  NTF_RESP_AVAIL = 8'h01;
  localparam logic [7:0]  NTF_LEN_LO     = 8'h02;
  localparam logic [3:0]  NTF_BYTES      = 4'ha;
  localparam logic [3:0]  NTF_LAST_IDX   = 4'h9;
  // bitmap field positions
  localparam int          BIT_OVERRUN    = 6;
  localparam int          BIT_PARITY     = 5;
  localparam int          BIT_FRAMING    = 4;
  // endpoints and pipe ranges
  localparam logic [3:0]  EP_BULK_IN     = 4'h1;
  localparam logic [3:0]  EP_BULK_OUT    = 4'h2;
  localparam logic [3:0]  PIPE_BULK_MIN  = 4'h1;
  localparam logic [3:0]  PIPE_BULK_MAX  = 4'h5;
  localparam logic [3:0]  PIPE_INT_MIN   = 4'h6;
  localparam logic [3:0]  PIPE_INT_MAX   = 4'h9;
  // line coding structure
  localparam logic [2:0]  LC_LEN         = 3'h7;
  localparam logic [2:0]  LC_IDX_STOP    = 3'h4;
  localparam logic [2:0]  LC_IDX_PARITY  = 3'h5;
  localparam logic [2:0]  LC_IDX_DBITS   = 3'h6;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_PIPE       = 8'h04;
  localparam logic [7:0]  REG_STATUS     = 8'h08;
  localparam logic [7:0]  REG_MASK       = 8'h0c;
  localparam logic [7:0]  REG_LC_RATE    = 8'h10;
  localparam logic [7:0]  REG_LC_FMT     = 8'h14;
  localparam logic [7:0]  REG_ERR        = 8'h18;
  // reset values
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [11:0] PIPE_RST       = 12'h621;
  // status bits
  localparam int          ST_NTF_SENT    = 0;
  localparam int          ST_LC_CHANGED  = 1;
  localparam int          ST_ZLP_SENT    = 2;
  localparam int          ST_CFG_ERR     = 3;
  localparam int          ST_W           = 4;
endpackage

/* hdl/csn_ntf_if.sv */
// handshake between the notifier control and the notification serialiser
`timescale 1ns/1ps
interface csn_ntf_if;
  logic        req;
  logic [15:0] bitmap;
  logic        busy;
  logic        done;
  modport ctl (output req, output bitmap, input busy, input done);
  modport tx  (input req, input bitmap, output busy, output done);
endinterface

/* hdl/csn_ntf_tx.sv */
// serialiser for the ten-byte serial-state notification
`timescale 1ns/1ps
module csn_ntf_tx
  import csn_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  csn_ntf_if.tx      ntf,
  output logic [7:0] data_o,
  output logic       valid_o,
  output logic       last_o,
  input  wire logic  ready_i
);
  logic [3:0]  idx;
  logic [15:0] map;

  // header byte for a given position; only the serial-state code exists
  function automatic logic [7:0] hdr_byte(input logic [3:0] i,
                                          input logic [15:0] m);
    unique case (i)
      4'h0:    hdr_byte = NTF_REQ_TYPE; // R5
      4'h1:    hdr_byte = NTF_SERIAL_ST; // R1
      4'h6:    hdr_byte = NTF_LEN_LO; // R5
      4'h8:    hdr_byte = m[7:0];
      4'h9:    hdr_byte = m[15:8];
      default: hdr_byte = 8'h00;
    endcase
  endfunction

  // byte walk; the sink may stall any byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx     <= 4'h0;
      map     <= 16'h0000;
      valid_o <= 1'b0;
      last_o  <= 1'b0;
      data_o  <= 8'h00;
      ntf.busy <= 1'b0;
      ntf.done <= 1'b0;
    end
    else
    begin
      ntf.done <= 1'b0;
      if (!ntf.busy && ntf.req)
      begin
        // reserved bits and unsupported line signals forced low
        map      <= ntf.bitmap & 16'h0070; // R6
        idx      <= 4'h0;
        ntf.busy <= 1'b1;
        valid_o  <= 1'b1;
        last_o   <= 1'b0;
        data_o   <= hdr_byte(4'h0, 16'h0000);
      end
      else if (valid_o && ready_i)
      begin
        if (idx == NTF_LAST_IDX)
        begin
          valid_o  <= 1'b0;
          last_o   <= 1'b0;
          ntf.busy <= 1'b0;
          ntf.done <= 1'b1;
        end
        else
        begin
          idx    <= idx + 4'h1;
          data_o <= hdr_byte(idx + 4'h1, map);
          last_o <= (idx + 4'h1) == NTF_LAST_IDX;
        end
      end
    end
  end

  AST_CODE_ONLY_SERIAL: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_o && idx == 4'h1 |-> data_o == NTF_SERIAL_ST) // R1
    else $error("notification code is not serial state");
  AST_HDR_TYPE: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_o && idx == 4'h0 |-> data_o == NTF_REQ_TYPE
      && data_o != NTF_NET_CONN && data_o != NTF_RESP_AVAIL) // R5
    else $error("bad notification request type");
  AST_HDR_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_o && idx == 4'h6 |-> data_o == NTF_LEN_LO) // R5
    else $error("bad notification length");
  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    valid_o && idx >= 4'h8 |-> (data_o & 8'h8f) == 8'h00
      || (idx == 4'h9 && data_o == 8'h00)) // R6
    else $error("reserved or unsupported bitmap bit set");
endmodule

/* bench/csn_host_model.sv */
// host-side sink for serial-state notification bytes
`timescale 1ns/1ps
module csn_host_model
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] data_i,
  input  wire logic       valid_i,
  input  wire logic       last_i,
  input  wire logic       stall_i,
  output logic            ready_o
);
  logic [7:0] rx_q[$];
  int         frames;
  // a host polls the interrupt pipe only now and then, so it stalls
  assign ready_o = !stall_i;
  // collect accepted bytes; a frame ends on the flagged byte
  always @(posedge clk_i)
    if (rst_i)
      frames <= 0;
    else if (valid_i && ready_o)
    begin
      rx_q.push_back(data_i);
      if (last_i)
        frames <= frames + 1;
    end
endmodule

/* bench/tb.sv */
// self-checking bench for the serial-state notifier
`timescale 1ns/1ps
module tb;
  import csn_pkg::*;
  localparam logic [10:0] MPK = 11'd16;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic        lc_we = 0, bi_pkt = 0, bi_last = 0, stall = 0;
  logic [7:0]  adr = 8'h00, lc_b = 8'h00;
  logic [2:0]  lc_idx = 3'h0, uerr = 3'h0;
  logic [10:0] bi_len = 11'h000;
  logic [31:0] dat = 32'h0, wb_dat_o, q;
  logic [15:0] lf = 16'h050f; // seed 1295
  logic [3:0]  bi_ep, bo_ep, bi_pipe, bo_pipe, int_pipe;
  logic        wb_ack_o, irq_o, bi_zlp_o, pipe_ok, nv, nl, nr;
  logic [7:0]  nd, b[7];
  logic [7:0]  exp_q[$];
  int          miscompares = 0, checks_done = 0, cyc_n = 0;
  logic [11:0] bad[5] = '{12'h733, 12'h521, 12'ha21, 12'h626, 12'h601};

  csn_top #(.MAX_PKT(MPK)) csn_top_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .uart_err_i(uerr),
    .lc_we_i(lc_we), .lc_idx_i(lc_idx), .lc_byte_i(lc_b),
    .bi_pkt_i(bi_pkt), .bi_len_i(bi_len), .bi_last_i(bi_last),
    .bi_zlp_o(bi_zlp_o), .bi_ep_o(bi_ep), .bo_ep_o(bo_ep),
    .bi_pipe_o(bi_pipe), .bo_pipe_o(bo_pipe), .int_pipe_o(int_pipe),
    .pipe_ok_o(pipe_ok), .ntf_data_o(nd), .ntf_valid_o(nv),
    .ntf_last_o(nl), .ntf_ready_i(nr));
  csn_host_model csn_host_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .data_i(nd), .valid_i(nv), .last_i(nl), .stall_i(stall),
    .ready_o(nr));

  always #12.5 clk_i = ~clk_i;

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // random host stalls; also the source of random stimulus bytes
  always @(posedge clk_i)
  begin
    lf <= lfsr_next(lf);
    stall <= lf[0] & lf[3];
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a hang is cut short well after the longest expected run
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // compare the host's collected bytes with the expected frame
  task automatic chk_frame();
    chk(csn_host_model_inst.rx_q.size(), exp_q.size(), "frame size");
    while (exp_q.size() > 0 && csn_host_model_inst.rx_q.size() > 0)
      chk(csn_host_model_inst.rx_q.pop_front(), exp_q.pop_front(), "byte");
    exp_q.delete();
  endtask

  // classic cycle: hold until ack is seen, release after that edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 0;
    stb <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0);
    chk(q, e, "reg read");
  endtask

  // raise errors from a clean line, expect one frame, then none more
  task automatic err_ev(input logic [2:0] e);
    int n;
    n = csn_host_model_inst.frames;
    @(posedge clk_i) uerr <= e;
    exp_q = '{8'ha1, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
              {1'b0, e, 4'h0}, 8'h00};
    repeat (300)
      if (csn_host_model_inst.frames == n)
        @(posedge clk_i);
    chk(csn_host_model_inst.frames, n + 1, "frame count");
    chk_frame();
    repeat (40) @(posedge clk_i);
    chk(csn_host_model_inst.frames, n + 1, "repeat notify");
    uerr <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic pkt(input logic [10:0] l, input logic t, input logic e);
    @(posedge clk_i);
    bi_pkt <= 1;
    bi_len <= l;
    bi_last <= t;
    @(posedge clk_i) bi_pkt <= 0;
    @(negedge clk_i) chk(bi_zlp_o, e, "zlp pulse");
    @(negedge clk_i) chk(bi_zlp_o, 0, "zlp width");
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    repeat (2) @(negedge clk_i);
    chk({bi_ep, bo_ep, bi_pipe, bo_pipe, int_pipe, pipe_ok},
        {4'h1, 4'h2, 4'h1, 4'h2, 4'h6, 1'b1}, "map");
    rd(REG_CTRL, 32'h0);
    rd(REG_PIPE, 32'h1621);
    rd(REG_MASK, 32'h0);
    rd(8'h40, 32'h0);
    wb(1, REG_CTRL, 32'h1);
    foreach (bad[i])
      err_ev(3'h4 >> i % 3);
    err_ev(3'h7);
    chk(irq_o, 0, "irq masked");
    wb(1, REG_MASK, 32'h1);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1, "irq raised");
    wb(1, REG_STATUS, 32'h1);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 0, "irq cleared");
    // set-line-coding data stage, sent whenever host settings change
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk_i);
      lc_we <= 1;
      lc_idx <= i[2:0];
      lc_b <= lf[7:0];
      b[i] = lf[7:0];
    end
    @(posedge clk_i) lc_we <= 0;
    rd(REG_LC_RATE, {b[3], b[2], b[1], b[0]});
    rd(REG_LC_FMT, {8'h00, b[6], b[5], b[4]});
    pkt(MPK, 1, 1);
    pkt(MPK - 11'd1, 1, 0);
    pkt(MPK, 0, 0);
    foreach (bad[i])
      wb(1, REG_PIPE, {20'h0, bad[i]});
    rd(REG_PIPE, 32'h1621);
    rd(REG_STATUS, 32'he);
    wb(1, REG_PIPE, 32'h943);
    repeat (2) @(negedge clk_i);
    chk({bi_pipe, bo_pipe, int_pipe, pipe_ok}, {4'h3, 4'h4, 4'h9, 1'b1},
        "new map");
    end_sim();
  end
endmodule
